/* hw/tcf_pkg.sv */
// Purpose: Constants for the telecom clock and frame output stage
// Assumes: Timebase clock of 10 MHz drives every output
// Notes: Pulse widths round up to whole timebase cycles

package tcf_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam longint CLOCK_HZ = 10000000;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int NCO_WIDTH = 32;

  // ----------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------
  localparam int FRAME_PERIOD_NS = 125000;
  localparam int CNT_WIDTH = 11;
  localparam logic [10:0] FRAME_CYCLES = 11'(FRAME_PERIOD_NS / CLOCK_PERIOD_NS);
  localparam logic [10:0] FRAME_LAST = 11'(FRAME_PERIOD_NS / CLOCK_PERIOD_NS - 1);

  localparam int OC3_HZ = 19440000;
  localparam int OC3_PULSE_NS = 1000000000 / OC3_HZ;
  localparam int PULSE_30_NS = 30;
  localparam int PULSE_61_NS = 61;
  localparam int PULSE_122_NS = 122;
  localparam int PULSE_244_NS = 244;
  localparam int PULSE_488_NS = 488;

  // Least times: round up, never below one cycle
  localparam logic [10:0] OC3_PULSE_CYC =
    11'((OC3_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [10:0] PULSE_30_CYC =
    11'((PULSE_30_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [10:0] PULSE_61_CYC =
    11'((PULSE_61_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [10:0] PULSE_122_CYC =
    11'((PULSE_122_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [10:0] PULSE_244_CYC =
    11'((PULSE_244_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [10:0] PULSE_488_CYC =
    11'((PULSE_488_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  // Frame pin levels between pulses: oc3 0, 30ns 1, 61ns 1, 122ns 0, 244ns 1, rx sync 0
  localparam logic [5:0] FRAME_IDLE = 6'h16;

  // ----------------------------------------------------------------
  // Line clock synthesis
  // ----------------------------------------------------------------
  localparam int NUM_CLK = 9;
  localparam int CLK_32M = 0;
  localparam int CLK_16M = 1;
  localparam int CLK_8M = 2;
  localparam int CLK_4M = 3;
  localparam int CLK_2M = 4;
  localparam int CLK_T1X2 = 5;
  localparam int CLK_T1 = 6;
  localparam int CLK_DS2 = 7;
  localparam int CLK_OC3 = 8;

  localparam longint CLK_HZ [NUM_CLK] = '{
    32768000, 16384000, 8192000, 4096000, 2048000,
    3088000, 1544000, 6312000, 19440000
  };

  // Reference rate codes on the rate-select inputs
  localparam logic [1:0] RATE_19M44 = 2'h0;
  localparam logic [1:0] RATE_8K = 2'h1;
  localparam logic [1:0] RATE_1M544 = 2'h2;
  localparam logic [1:0] RATE_2M048 = 2'h3;

endpackage

/* hw/tcf_frame_outputs.sv */
// Purpose: Line clocks and 8 kHz frame markers from the locked timebase
// Assumes: i_clock is the locked 10 MHz timebase; inputs are synchronous
// Notes: Clocks come from phase accumulators; rates above 5 MHz alias

`timescale 1ns/1ps
`default_nettype none

module tcf_frame_outputs
  import tcf_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_en,
  input wire logic i_reference_select,
  input wire logic [1:0] i_reference_a_rate,
  input wire logic [1:0] i_reference_b_rate,
  output logic o_clock_32m_out,
  output logic o_clock_16m_out,
  output logic o_clock_8m_out,
  output logic o_clock_4m_out,
  output logic o_clock_2m_out,
  output logic o_t1_double_clock_out,
  output logic o_t1_clock_out,
  output logic o_ds2_clock_out,
  output logic o_oc3_clock_out,
  output logic o_auto_e1_t1_clock_out,
  output logic o_oc3_frame_out,
  output logic o_frame_30ns_low_out_n,
  output logic o_frame_61ns_low_out_n,
  output logic o_frame_122ns_high_out,
  output logic o_frame_244ns_low_out_n,
  output logic o_receive_sync_out,
  output logic o_transmit_sync_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic rate_is_t1(input logic [1:0] rate);
    return rate == RATE_1M544;
  endfunction

  function automatic logic [NCO_WIDTH-1:0] nco_inc(input int idx);
    return NCO_WIDTH'((CLK_HZ[idx] << NCO_WIDTH) / CLOCK_HZ);
  endfunction

  // ----------------------------------------------------------------
  // Line clocks
  // ----------------------------------------------------------------
  logic [NCO_WIDTH-1:0] acc_r [NUM_CLK];
  logic [NCO_WIDTH-1:0] acc_nxt [NUM_CLK];
  logic [NUM_CLK-1:0] clk_out_r;
  logic [NUM_CLK-1:0] clk_out_nxt;
  logic auto_t1_r;
  logic auto_t1_nxt;
  logic auto_clk_r;
  logic auto_clk_nxt;

  always_comb begin
    for (int k = 0; k < NUM_CLK; k++) begin
      acc_nxt[k] = acc_r[k];
      clk_out_nxt[k] = clk_out_r[k];
    end
    auto_t1_nxt = auto_t1_r;
    auto_clk_nxt = auto_clk_r;
    if (i_clock_en) begin
      // All clocks step together off the one timebase
      for (int k = 0; k < NUM_CLK; k++) begin
        acc_nxt[k] = acc_r[k] + nco_inc(k);
        clk_out_nxt[k] = acc_nxt[k][NCO_WIDTH-1];
      end
      // Select input a when low, b when high
      auto_t1_nxt = i_reference_select ? rate_is_t1(i_reference_b_rate)
                                       : rate_is_t1(i_reference_a_rate);
      // T1 rate follows a 1.544 MHz reference, E1 otherwise
      auto_clk_nxt = auto_t1_nxt ? acc_nxt[CLK_T1][NCO_WIDTH-1]
                                 : acc_nxt[CLK_2M][NCO_WIDTH-1];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int k = 0; k < NUM_CLK; k++) begin
        acc_r[k] <= '0;
      end
      clk_out_r <= '0;
      auto_t1_r <= 1'b0;
      auto_clk_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      clk_out_r <= clk_out_nxt;
      auto_t1_r <= auto_t1_nxt;
      auto_clk_r <= auto_clk_nxt;
    end
  end

  assign o_clock_32m_out = clk_out_r[CLK_32M];
  assign o_clock_16m_out = clk_out_r[CLK_16M];
  assign o_clock_8m_out = clk_out_r[CLK_8M];
  assign o_clock_4m_out = clk_out_r[CLK_4M];
  assign o_clock_2m_out = clk_out_r[CLK_2M];
  assign o_t1_double_clock_out = clk_out_r[CLK_T1X2];
  assign o_t1_clock_out = clk_out_r[CLK_T1];
  assign o_ds2_clock_out = clk_out_r[CLK_DS2];
  assign o_oc3_clock_out = clk_out_r[CLK_OC3];
  assign o_auto_e1_t1_clock_out = auto_clk_r;

  // ----------------------------------------------------------------
  // Frame markers
  // ----------------------------------------------------------------
  logic [CNT_WIDTH-1:0] frame_cnt_r;
  logic [CNT_WIDTH-1:0] frame_cnt_nxt;
  logic [5:0] frame_r;
  logic [5:0] frame_nxt;
  logic tx_sync_r;
  logic tx_sync_nxt;

  // frame_r bits hold pin levels: oc3, 30ns, 61ns, 122ns, 244ns, rx sync
  always_comb begin
    frame_cnt_nxt = frame_cnt_r;
    frame_nxt = frame_r;
    tx_sync_nxt = tx_sync_r;
    if (i_clock_en) begin
      // One counter for every marker
      frame_cnt_nxt = (frame_cnt_r == FRAME_LAST) ? '0 : frame_cnt_r + 11'h001;
      frame_nxt[0] = frame_cnt_nxt < OC3_PULSE_CYC;
      frame_nxt[1] = frame_cnt_nxt >= PULSE_30_CYC;
      frame_nxt[2] = frame_cnt_nxt >= PULSE_61_CYC;
      frame_nxt[3] = frame_cnt_nxt < PULSE_122_CYC;
      frame_nxt[4] = frame_cnt_nxt >= PULSE_244_CYC;
      frame_nxt[5] = frame_cnt_nxt < PULSE_488_CYC;
      tx_sync_nxt = frame_cnt_nxt < PULSE_488_CYC;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      // Parked on the last count so the first frame starts on release
      frame_cnt_r <= FRAME_LAST;
      frame_r <= FRAME_IDLE;
      tx_sync_r <= 1'b0;
    end else begin
      frame_cnt_r <= frame_cnt_nxt;
      frame_r <= frame_nxt;
      tx_sync_r <= tx_sync_nxt;
    end
  end

  // Polarity lives in the flip-flops so every pin comes straight from one
  assign o_oc3_frame_out = frame_r[0];
  assign o_frame_30ns_low_out_n = frame_r[1];
  assign o_frame_61ns_low_out_n = frame_r[2];
  assign o_frame_122ns_high_out = frame_r[3];
  assign o_frame_244ns_low_out_n = frame_r[4];
  assign o_receive_sync_out = frame_r[5];
  assign o_transmit_sync_out = tx_sync_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_counter_wrap: assert property (@(posedge i_clock) disable iff (i_reset)
    i_clock_en && frame_cnt_r == FRAME_LAST |=> frame_cnt_r == '0)
    else $error("frame counter did not wrap");

  // Independent decode of the selected reference for the checks below
  logic sel_is_t1;
  assign sel_is_t1 = i_reference_select ? (i_reference_b_rate == RATE_1M544)
                                        : (i_reference_a_rate == RATE_1M544);

  a_auto_clock_src: assert property (@(posedge i_clock) disable iff (i_reset)
    i_clock_en |=> o_auto_e1_t1_clock_out == ($past(sel_is_t1) ? o_t1_clock_out
                                                               : o_clock_2m_out))
    else $error("auto clock follows wrong source");

  a_auto_select: assert property (@(posedge i_clock) disable iff (i_reset)
    i_clock_en |=> auto_t1_r == $past(sel_is_t1))
    else $error("auto clock rate does not match selected reference");

  a_oc3_frame_width: assert property (@(posedge i_clock)
    disable iff (i_reset || !i_clock_en)
    $rose(o_oc3_frame_out) |-> frame_cnt_r == '0 ##1 !o_oc3_frame_out)
    else $error("oc3 frame pulse width wrong");

  a_f30_width: assert property (@(posedge i_clock) disable iff (i_reset || !i_clock_en)
    $fell(o_frame_30ns_low_out_n) |-> ##1 o_frame_30ns_low_out_n)
    else $error("30 ns frame pulse width wrong");

  a_f61_align: assert property (@(posedge i_clock) disable iff (i_reset)
    !o_frame_61ns_low_out_n == (frame_cnt_r < PULSE_61_CYC))
    else $error("61 ns frame pulse misaligned");

  a_f122_width: assert property (@(posedge i_clock) disable iff (i_reset || !i_clock_en)
    $rose(o_frame_122ns_high_out) |-> o_frame_122ns_high_out[*2] ##1 !o_frame_122ns_high_out)
    else $error("122 ns frame pulse width wrong");

  a_f244_width: assert property (@(posedge i_clock) disable iff (i_reset || !i_clock_en)
    $fell(o_frame_244ns_low_out_n) |-> !o_frame_244ns_low_out_n[*3] ##1 o_frame_244ns_low_out_n)
    else $error("244 ns frame pulse width wrong");

  a_rx_sync_width: assert property (@(posedge i_clock) disable iff (i_reset || !i_clock_en)
    $rose(o_receive_sync_out) |-> frame_cnt_r == '0 ##0 o_receive_sync_out[*5]
      ##1 !o_receive_sync_out)
    else $error("receive sync pulse width wrong");

  a_tx_sync_match: assert property (@(posedge i_clock) disable iff (i_reset)
    o_transmit_sync_out == o_receive_sync_out
      && o_transmit_sync_out == (frame_cnt_r < PULSE_488_CYC))
    else $error("transmit sync pulse misaligned");

  a_ds2_runs: assert property (@(posedge i_clock) disable iff (i_reset || !i_clock_en)
    o_ds2_clock_out |-> ##[1:4] !o_ds2_clock_out)
    else $error("ds2 clock stuck high");

  a_t1_runs: assert property (@(posedge i_clock) disable iff (i_reset || !i_clock_en)
    !o_t1_clock_out |-> ##[1:8] o_t1_clock_out)
    else $error("t1 clock stuck low");

  c_frame_start: cover property (@(posedge i_clock) disable iff (i_reset)
    $rose(o_receive_sync_out));
  c_auto_t1: cover property (@(posedge i_clock) disable iff (i_reset) auto_t1_r);
  c_auto_switch: cover property (@(posedge i_clock) disable iff (i_reset) $fell(auto_t1_r));
  c_frame_wrap: cover property (@(posedge i_clock) disable iff (i_reset)
    frame_cnt_r == FRAME_LAST);

endmodule

`default_nettype wire

/* sim/tcf_framer_model.sv */
// Purpose: Framer that consumes the 244 ns active-low frame marker
// Assumes: The marker is sampled on rising edges of the timebase
// Notes: Reports frames seen and the width of the last marker in cycles

`timescale 1ns/1ps
`default_nettype none

module tcf_framer_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_frame_n,
  output logic [15:0] o_frames,
  output logic [7:0] o_width
);
  logic [7:0] run_r;
  logic prev_r;

  // Frame start is the falling edge, width is measured up to the rise
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_frames <= 16'h0;
      o_width <= 8'h0;
      run_r <= 8'h0;
      prev_r <= 1'b1;
    end else begin
      prev_r <= i_frame_n;
      run_r <= i_frame_n ? 8'h0 : run_r + 8'h1;
      if (!i_frame_n && prev_r) begin
        o_frames <= o_frames + 16'h1;
      end
      if (i_frame_n && !prev_r) begin
        o_width <= run_r;
      end
    end
  end
endmodule

`default_nettype wire

/* sim/testbench.sv */
// Purpose: Self-checking bench for the clock and frame output stage
// Assumes: 10 MHz timebase, inputs driven on the falling edge
// Notes: A reference accumulator and frame counter predict every output

`timescale 1ns/1ps
`default_nettype none

module testbench;
  import tcf_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_clock_en = 1'b1;
  logic i_reference_select = 1'b0;
  logic [1:0] i_reference_a_rate = RATE_19M44;
  logic [1:0] i_reference_b_rate = RATE_19M44;
  wire [8:0] clk_v;
  logic o_auto, o_oc3f, o_f30_n, o_f61_n, o_f122, o_f244_n, o_rx_sync, o_tx_sync;
  logic [15:0] frames;
  logic [7:0] width;
  logic [31:0] inc [NUM_CLK];
  logic [31:0] acc [NUM_CLK];
  logic [10:0] cnt;
  logic auto_exp;
  logic [1:0] rate;
  int fail_count = 0;
  int n_tests = 0;

  always #50 i_clock = ~i_clock;

  tcf_frame_outputs u_tcf_frame_outputs (.i_clock(i_clock), .i_reset(i_reset),
    .i_clock_en(i_clock_en), .i_reference_select(i_reference_select),
    .i_reference_a_rate(i_reference_a_rate), .i_reference_b_rate(i_reference_b_rate),
    .o_clock_32m_out(clk_v[CLK_32M]), .o_clock_16m_out(clk_v[CLK_16M]),
    .o_clock_8m_out(clk_v[CLK_8M]), .o_clock_4m_out(clk_v[CLK_4M]),
    .o_clock_2m_out(clk_v[CLK_2M]), .o_t1_double_clock_out(clk_v[CLK_T1X2]),
    .o_t1_clock_out(clk_v[CLK_T1]), .o_ds2_clock_out(clk_v[CLK_DS2]),
    .o_oc3_clock_out(clk_v[CLK_OC3]), .o_auto_e1_t1_clock_out(o_auto),
    .o_oc3_frame_out(o_oc3f), .o_frame_30ns_low_out_n(o_f30_n),
    .o_frame_61ns_low_out_n(o_f61_n), .o_frame_122ns_high_out(o_f122),
    .o_frame_244ns_low_out_n(o_f244_n), .o_receive_sync_out(o_rx_sync),
    .o_transmit_sync_out(o_tx_sync));

  tcf_framer_model u_tcf_framer_model (.i_clock(i_clock), .i_reset(i_reset),
    .i_frame_n(o_f244_n), .o_frames(frames), .o_width(width));

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  initial begin
    for (int k = 0; k < NUM_CLK; k++) begin
      inc[k] = 32'((CLK_HZ[k] * 64'h100000000) / 64'd10000000);
    end
  end

  assign rate = i_reference_select ? i_reference_b_rate : i_reference_a_rate;

  always @(posedge i_clock) begin
    if (i_reset) begin
      for (int k = 0; k < NUM_CLK; k++) acc[k] <= 32'h0;
      cnt <= 11'h4e1;
      auto_exp <= 1'b0;
    end else if (i_clock_en) begin
      for (int k = 0; k < NUM_CLK; k++) acc[k] <= acc[k] + inc[k];
      cnt <= (cnt == 11'h4e1) ? 11'h0 : cnt + 11'h1;
      auto_exp <= (rate == RATE_1M544) ? 1'((acc[CLK_T1] + inc[CLK_T1]) >> 31)
                                       : 1'((acc[CLK_2M] + inc[CLK_2M]) >> 31);
    end
  end

  // ------------------------------------------------------------
  // Compare and run helpers
  // ------------------------------------------------------------
  function automatic logic act(input int ns);
    return cnt < 11'((ns + 99) / 100);
  endfunction

  task automatic check_bit(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b at %0t", name, exp, got, $time);
    end
  endtask

  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h at %0t", name, exp, got, $time);
    end
  endtask

  task automatic check_outputs();
    for (int k = 0; k < NUM_CLK; k++) begin
      check_bit($sformatf("clock %0d", k), acc[k][31], clk_v[k]);
    end
    check_bit("auto clock", auto_exp, o_auto);
    check_bit("oc3 frame", act(1000000000 / 19440000), o_oc3f);
    check_bit("frame 30", !act(30), o_f30_n);
    check_bit("frame 61", !act(61), o_f61_n);
    check_bit("frame 122", act(122), o_f122);
    check_bit("frame 244", !act(244), o_f244_n);
    check_bit("receive sync", act(488), o_rx_sync);
    check_bit("transmit sync", act(488), o_tx_sync);
  endtask

  task automatic run(input int n);
    repeat (n) begin
      @(negedge i_clock);
      check_outputs();
    end
  endtask

  task automatic do_reset();
    i_reset = 1'b1;
    run(2);
    i_reset = 1'b0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_frames();
    do_reset();
    run(1300);
    check_val("framer width", 16'h0003, {8'h00, width});
    check_val("framer count", 16'h0002, frames);
    $display("test frames done");
  endtask

  task automatic t_auto();
    for (int s = 0; s < 2; s++) begin
      for (int r = 0; r < 4; r++) begin
        i_reference_select = s[0];
        i_reference_a_rate = s ? ((r == 2) ? RATE_2M048 : RATE_1M544) : r[1:0];
        i_reference_b_rate = s ? r[1:0] : ((r == 2) ? RATE_2M048 : RATE_1M544);
        run(24);
      end
    end
    $display("test auto clock done");
  endtask

  task automatic t_freeze();
    do_reset();
    run(1);
    i_clock_en = 1'b0;
    run(6);
    i_clock_en = 1'b1;
    run(8);
    $display("test freeze done");
  endtask

  task automatic t_mid_reset();
    run(3);
    do_reset();
    run(8);
    $display("test mid reset done");
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    t_frames();
    t_auto();
    t_freeze();
    t_mid_reset();
    complete_run();
  end

  initial begin
    #(4000 * 100);
    fail_count++;
    complete_run();
  end
endmodule

`default_nettype wire
